//--- logic/pue_pkg.sv
/*
  Package for the phase undervoltage element: register map, field
  positions, reset values, timing figures and carrier types.
  Assumes a 40 MHz system clock and a same-clock measurement front end.
*/
`default_nettype none
package pue_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PUE_VW  = 12;
  localparam int unsigned PUE_SW  = 10;
  localparam int unsigned PUE_DW  = 17;
  localparam int unsigned PUE_AW  = 8;
  localparam int unsigned PUE_EW  = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] PUE_OFS_CTRL   = 8'h00;
  localparam logic [7:0] PUE_OFS_PICKUP = 8'h04;
  localparam logic [7:0] PUE_OFS_DELAY  = 8'h08;
  localparam logic [7:0] PUE_OFS_MINV   = 8'h0c;
  localparam logic [7:0] PUE_OFS_STAT   = 8'h10;
  localparam logic [7:0] PUE_OFS_EVT    = 8'h14;
  localparam logic [7:0] PUE_OFS_EVCLR  = 8'h18;
  localparam logic [7:0] PUE_OFS_EVEN   = 8'h1c;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int unsigned PUE_CTL_EN    = 0;
  localparam int unsigned PUE_CTL_LG    = 1;
  localparam int unsigned PUE_CTL_INV   = 2;
  localparam int unsigned PUE_CTL_LOGIC = 3;
  localparam int unsigned PUE_CTL_BRK   = 5;
  localparam int unsigned PUE_CTL_SNAP  = 6;
  localparam int unsigned PUE_CTL_W     = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [6:0]  PUE_CTRL_RST   = 7'h40;
  localparam logic [9:0]  PUE_PICKUP_RST = 10'h032;
  localparam logic [16:0] PUE_DELAY_RST  = 17'h003e8;
  localparam logic [9:0]  PUE_MINV_RST   = 10'h000;
  localparam logic [7:0]  PUE_EVEN_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned PUE_CLK_NS  = 25;
  localparam int unsigned PUE_TICK_NS = 10_000_000;
  localparam int unsigned PUE_TICK_CYC = PUE_TICK_NS / PUE_CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PUE_ANY = 2'h0,
    PUE_TWO = 2'h1,
    PUE_ALL = 2'h2
  } pue_logic_t;

  typedef struct packed
  {
    logic                        valid;
    logic [2:0][PUE_VW-1:0]      v_ll;
    logic [2:0][PUE_VW-1:0]      v_lg;
  } pue_sample_t;

  typedef struct packed
  {
    logic [2:0] pick;
    logic [2:0] trip;
    logic       gen_pick;
    logic       gen_trip;
  } pue_out_t;

endpackage
`default_nettype wire

//--- logic/pue_pin_sync.sv
/*
  Three-stage synchroniser for a level arriving from a pin.
  Assumes the pin is asynchronous to mclk; output follows once the
  second and third stages agree.
*/
`default_nettype none
`timescale 1ns/10ps
module pue_pin_sync
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic pin,
  output var  logic level_ff
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      level_ff <= 1'b0;
    else if (s2_ff == s3_ff)
      level_ff <= s3_ff;
  end

  a_sync_agree: assert property (@(posedge mclk) disable iff (!reset_n)
    level_ff != $past(level_ff) |-> $past(s2_ff) == $past(s3_ff))
    else $error("level changed without stage agreement");

endmodule
`default_nettype wire

//--- logic/pue_phase.sv
/*
  One phase of the undervoltage element: compare, block and time.
  Assumes sample_stb marks a new magnitude and tick is a 10 ms pulse.
*/
`default_nettype none
`timescale 1ns/10ps
module pue_phase
  import pue_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              tick,
  input  wire logic              sample_stb,
  input  wire logic [PUE_VW-1:0] volt,
  input  wire logic [PUE_SW-1:0] pickup_lvl,
  input  wire logic [PUE_SW-1:0] min_lvl,
  input  wire logic [PUE_DW-1:0] delay,
  input  wire logic              inverse,
  input  wire logic              allow,
  output var  logic              pick_ff,
  output var  logic              trip_ff
);
  typedef enum logic [1:0]
  {
    PUE_IDLE = 2'h0,
    PUE_TIME = 2'h1,
    PUE_TRIP = 2'h3
  } pue_ph_state_t;

  localparam int unsigned AW = PUE_DW + PUE_SW + 1;

  pue_ph_state_t     state_ff;
  pue_ph_state_t     nxt_state;
  logic              under_ff;
  logic [PUE_VW-1:0] volt_ff;
  logic [AW-1:0]     acc_ff;
  logic [AW-1:0]     target;
  logic [AW-1:0]     step;
  logic              active;
  logic              done;

  // Compare only on a fresh sample
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      under_ff <= 1'b0;
      volt_ff  <= '0;
    end
    else if (sample_stb)
    begin
      volt_ff  <= volt;
      under_ff <= (volt < {2'h0, pickup_lvl}) &&
                  !(volt < {2'h0, min_lvl});
    end
  end

  assign active = under_ff && allow;
  // D*Vp is the area to integrate; fixed adds Vp, inverse adds Vp-V
  // Widen both factors first so the product keeps its upper bits
  assign target = AW'(delay) * AW'(pickup_lvl);
  assign step   = inverse ? AW'(pickup_lvl - volt_ff[PUE_SW-1:0])
                          : AW'(pickup_lvl);
  // Strictly past the target, so a tick phase never trips early
  assign done   = (delay == '0) || (acc_ff > target);

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      PUE_IDLE: if (active) nxt_state = PUE_TIME;
      PUE_TIME:
        if (!active)
          nxt_state = PUE_IDLE;
        else if (done)
          nxt_state = PUE_TRIP;
      PUE_TRIP: if (!active) nxt_state = PUE_IDLE;
      default:  nxt_state = PUE_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      state_ff <= PUE_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n || state_ff != PUE_TIME)
      acc_ff <= '0;
    else if (tick && acc_ff <= target)
      acc_ff <= acc_ff + step;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pick_ff <= 1'b0;
      trip_ff <= 1'b0;
    end
    else
    begin
      pick_ff <= nxt_state != PUE_IDLE;
      trip_ff <= nxt_state == PUE_TRIP;
    end
  end

  a_trip_has_pick: assert property (@(posedge mclk) disable iff (!reset_n)
    trip_ff |-> pick_ff)
    else $error("trip without pickup");

  a_drop_instant: assert property (@(posedge mclk) disable iff (!reset_n)
    !active |=> !pick_ff && !trip_ff)
    else $error("pickup held after dropout");

  a_trip_not_early: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(trip_ff) |-> $past(done))
    else $error("trip before delay elapsed");

endmodule
`default_nettype wire

//--- logic/pue_top.sv
/*
  Phase undervoltage element, top level: register port, breaker
  supervision, three phase timers, combination logic and events.
  Assumes samples arrive on mclk from the front end and the breaker
  status pin is asynchronous.
*/
// Operation
// - Fixed delay trips after full delay below
// - Inverse time is delay over one minus ratio
// - Above dropout clears pickup and timer instantly
// - Below floor voltage the element is blocked
// - Per phase and general pickup and trip
// - General outputs: any, two or all phases
// - Disabled element keeps outputs off; reset disabled
// - Line-to-line or line-to-ground input, default line
// - Undervoltage below threshold, 3..850 V, default 50
// - Delay in 10 ms steps, default 10 s
// - Floor setting 0..850 V, default zero
// - Breaker supervision blocks while breaker open
// - Events recorded only while generation enabled
// - Curve setting picks fixed or inverse, default fixed
// - Delay is the minimum operate time
`default_nettype none
`timescale 1ns/10ps
module pue_top
  import pue_pkg::*;
#(
  parameter int unsigned TICK_CYC = PUE_TICK_CYC
)
(
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic [PUE_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [31:0]       reg_rdata_ff,
  input  wire pue_sample_t       sample,
  input  wire logic              breaker_open,
  output var  pue_out_t          elem_ff,
  output var  logic              irq_ff
);
  import pue_pkg::*;

  // ----------------------------------------------------------------
  // Settings registers
  // ----------------------------------------------------------------
  logic [PUE_CTL_W-1:0] ctrl_ff;
  logic [PUE_SW-1:0]    pickup_ff;
  logic [PUE_DW-1:0]    delay_ff;
  logic [PUE_SW-1:0]    minv_ff;
  logic [PUE_EW-1:0]    evt_en_ff;
  logic [PUE_EW-1:0]    evt_ff;
  logic [PUE_EW-1:0]    nxt_evt;
  logic [PUE_EW-1:0]    evt_clr;
  logic [PUE_EW-1:0]    prev_ff;
  logic [PUE_EW-1:0]    cur;
  logic                 wr_ctrl;

  assign wr_ctrl = reg_wr && reg_addr == PUE_OFS_CTRL;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl_ff   <= PUE_CTRL_RST;
      pickup_ff <= PUE_PICKUP_RST;
      delay_ff  <= PUE_DELAY_RST;
      minv_ff   <= PUE_MINV_RST;
      evt_en_ff <= PUE_EVEN_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        PUE_OFS_CTRL:   ctrl_ff   <= reg_wdata[PUE_CTL_W-1:0];
        PUE_OFS_PICKUP: pickup_ff <= reg_wdata[PUE_SW-1:0];
        PUE_OFS_DELAY:  delay_ff  <= reg_wdata[PUE_DW-1:0];
        PUE_OFS_MINV:   minv_ff   <= reg_wdata[PUE_SW-1:0];
        PUE_OFS_EVEN:   evt_en_ff <= reg_wdata[PUE_EW-1:0];
        default:        ;
      endcase
    end
  end

  logic       en;
  logic       sel_lg;
  logic       inverse;
  logic       brk_sup;
  logic       snap_en;
  pue_logic_t comb_sel;

  assign en       = ctrl_ff[PUE_CTL_EN];
  assign sel_lg   = ctrl_ff[PUE_CTL_LG];
  assign inverse  = ctrl_ff[PUE_CTL_INV];
  assign brk_sup  = ctrl_ff[PUE_CTL_BRK];
  assign snap_en  = ctrl_ff[PUE_CTL_SNAP];
  assign comb_sel = pue_logic_t'(ctrl_ff[PUE_CTL_LOGIC +: 2]);

  // ----------------------------------------------------------------
  // Breaker status and permission
  // ----------------------------------------------------------------
  logic brk_open_s;
  logic allow;

  pue_pin_sync u_brk_sync
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pin      (breaker_open),
    .level_ff (brk_open_s)
  );

  // Permission and breaker act at once, not on the next sample
  assign allow = en && !(brk_sup && brk_open_s);

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int unsigned TW = $clog2(TICK_CYC + 1);

  logic [TW-1:0] tick_cnt_ff;
  logic          tick_ff;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b0;
    end
    else if (tick_cnt_ff == TW'(TICK_CYC - 1))
    begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
      tick_ff     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Phase timers
  // ----------------------------------------------------------------
  logic [2:0] ph_pick;
  logic [2:0] ph_trip;

  for (genvar i = 0; i < 3; i++)
  begin : g_ph
    pue_phase u_ph
    (
      .mclk       (mclk),
      .reset_n    (reset_n),
      .tick       (tick_ff),
      .sample_stb (sample.valid),
      .volt       (sel_lg ? sample.v_lg[i] : sample.v_ll[i]),
      .pickup_lvl (pickup_ff),
      .min_lvl    (minv_ff),
      .delay      (delay_ff),
      .inverse    (inverse),
      .allow      (allow),
      .pick_ff    (ph_pick[i]),
      .trip_ff    (ph_trip[i])
    );
  end

  // ----------------------------------------------------------------
  // General outputs
  // ----------------------------------------------------------------
  function automatic logic combine(input logic [2:0] v,
                                   input pue_logic_t s);
    logic [1:0] n;
    n = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    unique case (s)
      PUE_TWO: combine = n >= 2'h2;
      PUE_ALL: combine = n == 2'h3;
      default: combine = n != 2'h0;
    endcase
  endfunction

  // Phase flops are copied so every output leaves from this level
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      elem_ff <= '0;
    else
    begin
      elem_ff.pick     <= ph_pick;
      elem_ff.trip     <= ph_trip;
      elem_ff.gen_pick <= combine(ph_pick, comb_sel);
      elem_ff.gen_trip <= combine(ph_trip, comb_sel);
    end
  end

  // ----------------------------------------------------------------
  // Snapshot events and interrupt
  // ----------------------------------------------------------------
  assign cur     = elem_ff;
  assign evt_clr = (reg_wr && reg_addr == PUE_OFS_EVCLR)
                   ? reg_wdata[PUE_EW-1:0] : '0;
  // A change in the clearing cycle survives: set wins
  assign nxt_evt = (evt_ff & ~evt_clr) |
                   ((cur ^ prev_ff) & {PUE_EW{snap_en}});

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      prev_ff <= '0;
      evt_ff  <= '0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      prev_ff <= cur;
      evt_ff  <= nxt_evt;
      irq_ff  <= |(nxt_evt & evt_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !reg_rd)
      reg_rdata_ff <= '0;
    else
    begin
      unique case (reg_addr)
        PUE_OFS_CTRL:   reg_rdata_ff <= 32'(ctrl_ff);
        PUE_OFS_PICKUP: reg_rdata_ff <= 32'(pickup_ff);
        PUE_OFS_DELAY:  reg_rdata_ff <= 32'(delay_ff);
        PUE_OFS_MINV:   reg_rdata_ff <= 32'(minv_ff);
        PUE_OFS_STAT:   reg_rdata_ff <= 32'({brk_open_s, cur});
        PUE_OFS_EVT:    reg_rdata_ff <= 32'(evt_ff);
        PUE_OFS_EVEN:   reg_rdata_ff <= 32'(evt_en_ff);
        default:        reg_rdata_ff <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_disabled2;
    !en [*2];
  endsequence

  sequence s_quiet;
    elem_ff == '0;
  endsequence

  a_disabled_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    s_disabled2 |=> s_quiet)
    else $error("outputs active while disabled");

  a_general_any: assert property (@(posedge mclk) disable iff (!reset_n)
    comb_sel == PUE_ANY && $stable(comb_sel) |=>
      elem_ff.gen_pick == |$past(ph_pick))
    else $error("any-phase pickup mismatch");

  a_general_all: assert property (@(posedge mclk) disable iff (!reset_n)
    comb_sel == PUE_ALL && $stable(comb_sel) && elem_ff.gen_trip
      |-> &elem_ff.trip)
    else $error("all-phase trip without three phases");

  a_breaker_block: assert property (@(posedge mclk) disable iff (!reset_n)
    (brk_sup && brk_open_s) [*3] |-> elem_ff.pick == 3'h0)
    else $error("pickup while breaker open");

  a_snap_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(snap_en) && !$past(evt_ff[0]) |-> !evt_ff[0])
    else $error("event recorded while generation off");

  a_event_set: assert property (@(posedge mclk) disable iff (!reset_n)
    snap_en && cur[0] != prev_ff[0] |=> evt_ff[0])
    else $error("output change lost");

  a_read_once: assert property (@(posedge mclk) disable iff (!reset_n)
    !reg_rd |=> reg_rdata_ff == '0)
    else $error("read data outside answer cycle");

  a_tick_spacing: assert property (@(posedge mclk) disable iff (!reset_n)
    tick_ff |=> !tick_ff)
    else $error("time base pulse too long");

endmodule
`default_nettype wire

//--- tb/pue_front_end.sv
/*
  Model of the measurement front end and the breaker contact.
  Assumes the bench sets the phase magnitudes; one sample every 4 clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module pue_front_end
  import pue_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic [2:0][PUE_VW-1:0] ll,
  input  wire logic [2:0][PUE_VW-1:0] lg,
  input  wire logic                   brk,
  output var  pue_sample_t            sample,
  output var  logic                   breaker_open
);
  import pue_pkg::*;
  logic [1:0]  div_ff = 2'h0;
  pue_sample_t smp_ff = '0;

  // ----------------------------------------------------------------
  // Sample cadence
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    div_ff <= reset_n ? div_ff + 2'h1 : 2'h0;
    smp_ff.valid <= reset_n && (div_ff == 2'h3);
    // Magnitudes mean nothing without valid, so scramble them
    smp_ff.v_ll <= (div_ff == 2'h3) ? ll : ~ll;
    smp_ff.v_lg <= (div_ff == 2'h3) ? lg : ~lg;
  end
  assign sample = smp_ff;
  // Field contact: a plain level, the element synchronises it
  assign breaker_open = brk;
endmodule
`default_nettype wire

//--- tb/test_phase_undervoltage_element.sv
/*
  Self-checking bench for the phase undervoltage element.
  Assumes pue_top with a 20-cycle time base and the front end model.
*/
`timescale 1ns/10ps
`default_nettype none
module test_phase_undervoltage_element;
  import pue_pkg::*;
  localparam logic [11:0] HI = 12'h064;
  localparam logic [11:0] LO = 12'h028;
  logic                   mclk = 1'b0;
  logic                   reset_n = 1'b0;
  logic [PUE_AW-1:0]      reg_addr = '0;
  logic [31:0]            reg_wdata = '0;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [31:0]            reg_rdata_ff;
  pue_sample_t            sample;
  logic                   breaker_open;
  pue_out_t               elem_ff;
  logic                   irq_ff;
  logic [2:0][PUE_VW-1:0] ll = {3{HI}};
  logic [2:0][PUE_VW-1:0] lg = {3{HI}};
  logic                   brk = 1'b0;
  int                     bad_count = 0;
  int                     checked = 0;

  always #12.5 mclk = ~mclk;

  pue_top #(.TICK_CYC(20)) u_pue_top
  (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata_ff (reg_rdata_ff),
    .sample       (sample),
    .breaker_open (breaker_open),
    .elem_ff      (elem_ff),
    .irq_ff       (irq_ff)
  );

  pue_front_end u_pue_front_end
  (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .ll           (ll),
    .lg           (lg),
    .brk          (brk),
    .sample       (sample),
    .breaker_open (breaker_open)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk_reg(reg_rdata_ff, exp);
  endtask

  task automatic volts(input logic [11:0] a, b, c);
    @(posedge mclk);
    ll <= {c, b, a};
  endtask

  // Sample spacing 4 plus 3-cycle path: 8 cycles covers a change
  task automatic look(input int n, input logic [7:0] m, x);
    repeat (n) @(posedge mclk);
    #1 chk_out(elem_ff & m, x);
  endtask

  task automatic calm;
    volts(HI, HI, HI);
    look(10, 8'hff, 8'h00);
  endtask

  task automatic wait_bit(input logic [7:0] m, output int n);
    for (n = 0; (elem_ff & m) !== m; n++)
    begin
      if (n > 200)
      begin
        bad_count++;
        conclude();
      end
      @(posedge mclk);
      #1;
    end
  endtask

  // Cycles from phase 0 pickup to phase 0 trip, then all outputs
  task automatic trip_time(input int lo, input int hi);
    int n;
    wait_bit(8'h20, n);
    wait_bit(8'h04, n);
    chk_out({7'h00, (n >= lo) && (n <= hi)}, 8'h01);
    chk_out(elem_ff, 8'h27);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_reset;
    rd(PUE_OFS_CTRL, 32'h40);
    rd(PUE_OFS_PICKUP, 32'h32);
    rd(PUE_OFS_DELAY, 32'h3e8);
    rd(PUE_OFS_MINV, 32'h0);
    wr(PUE_OFS_STAT, 32'hff);
    wr(8'h20, 32'hff);
    rd(PUE_OFS_STAT, 32'h0);
    rd(8'h20, 32'h0);
    rd(PUE_OFS_EVCLR, 32'h0);
  endtask

  task automatic sc_disabled;
    volts(LO, LO, LO);
    look(12, 8'hff, 8'h00);
    calm();
  endtask

  task automatic sc_fixed;
    wr(PUE_OFS_DELAY, 32'h3);
    wr(PUE_OFS_CTRL, 32'h41);
    volts(LO, HI, HI);
    trip_time(60, 86);
    calm();
  endtask

  task automatic sc_logic;
    volts(LO, LO, HI);
    for (int m = 0; m < 3; m++)
    begin
      wr(PUE_OFS_CTRL, 32'h41 | (m << 3));
      look(12, 8'he2, (m == 2) ? 8'h60 : 8'h62);
    end
    volts(LO, HI, HI);
    wr(PUE_OFS_CTRL, 32'h49);
    look(12, 8'he2, 8'h20);
    calm();
  endtask

  task automatic sc_floor;
    wr(PUE_OFS_MINV, 32'h1e);
    volts(12'h014, HI, HI);
    look(12, 8'he0, 8'h00);
    volts(12'h01e, HI, HI);
    look(12, 8'he0, 8'h20);
    wr(PUE_OFS_MINV, 32'h0);
    volts(12'h000, HI, HI);
    look(12, 8'he0, 8'h20);
    calm();
  endtask

  task automatic sc_breaker;
    @(posedge mclk);
    brk <= 1'b1;
    wr(PUE_OFS_CTRL, 32'h61);
    volts(LO, HI, HI);
    look(12, 8'he0, 8'h00);
    rd(PUE_OFS_STAT, 32'h100);
    wr(PUE_OFS_CTRL, 32'h41);
    look(12, 8'he0, 8'h20);
    @(posedge mclk);
    brk <= 1'b0;
    calm();
  endtask

  task automatic sc_ground;
    wr(PUE_OFS_CTRL, 32'h43);
    lg <= {HI, HI, LO};
    look(12, 8'he0, 8'h20);
    wr(PUE_OFS_CTRL, 32'h41);
    look(12, 8'he0, 8'h00);
    lg <= {3{HI}};
  endtask

  // T = 2 / (1 - 50/100) = 4 ticks, trips on the 5th; fixed curve would trip on the 3rd
  task automatic sc_inverse;
    wr(PUE_OFS_PICKUP, 32'h64);
    wr(PUE_OFS_DELAY, 32'h2);
    wr(PUE_OFS_CTRL, 32'h45);
    volts(12'h032, HI, HI);
    trip_time(80, 106);
    calm();
  endtask

  task automatic sc_irq;
    wr(PUE_OFS_EVCLR, 32'hff);
    rd(PUE_OFS_EVT, 32'h0);
    wr(PUE_OFS_EVEN, 32'h20);
    volts(12'h032, HI, HI);
    look(12, 8'he0, 8'h20);
    chk_out({7'h00, irq_ff}, 8'h01);
    rd(PUE_OFS_EVT, 32'h22);
    wr(PUE_OFS_EVEN, 32'h0);
    repeat (2) @(posedge mclk);
    #1 chk_out({7'h00, irq_ff}, 8'h00);
    wr(PUE_OFS_EVCLR, 32'hff);
    wr(PUE_OFS_CTRL, 32'h05);
    calm();
    rd(PUE_OFS_EVT, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    sc_reset();
    sc_disabled();
    sc_fixed();
    sc_logic();
    sc_floor();
    sc_breaker();
    sc_ground();
    sc_inverse();
    sc_irq();
    conclude();
  end
endmodule
`default_nettype wire
